// ==== hw/ebc_pkg.sv ====
// Constants, field layout and types of the event binning counter store.
// Assumes one system clock; included by both design files.
`default_nettype none

package ebc_pkg;

  localparam int          BYTE_W      = 8;
  localparam int          CNT_W       = 24;
  localparam int          N_BOUND     = 31;
  localparam int          MEM_ADDR_W  = 13;
  localparam logic [7:0]  BIN_LAST    = 8'h1f;
  localparam logic [23:0] CNT_ALL1    = 24'hffffff;

  // Slot cycle of the memory sequencer
  localparam logic [3:0]  SLOT_LAST   = 4'h8;
  localparam logic [3:0]  SLOT_RD_END = 4'h2;
  localparam logic [3:0]  SLOT_CAP0   = 4'h3;
  localparam logic [3:0]  SLOT_CAP_END = 4'h5;
  localparam logic [3:0]  SLOT_WR0    = 4'h6;
  localparam logic [1:0]  OFS_LSB     = 2'h3;
  localparam logic [8:0]  INIT_LAST   = 9'h1ff;

  // Register offsets (byte addresses)
  localparam logic [7:0]  ADR_CTRL    = 8'h00;
  localparam logic [7:0]  ADR_CMD     = 8'h04;
  localparam logic [7:0]  ADR_RDREQ   = 8'h08;
  localparam logic [7:0]  ADR_RDDATA  = 8'h0c;
  localparam logic [7:0]  ADR_STATUS  = 8'h10;
  localparam logic [7:0]  ADR_BOUND   = 8'h80;

  // Field positions
  localparam int          CTRL_BINNED = 0;
  localparam int          CTRL_PAGE   = 1;
  localparam int          CTRL_EN     = 3;
  localparam int          CMD_IRQCLR  = 0;
  localparam int          CMD_INIT    = 1;
  localparam int          RQ_PAGE     = 8;
  localparam int          RQ_CHIP     = 10;
  localparam int          RD_VALID    = 24;
  localparam int          ST_SAT      = 0;
  localparam int          ST_INIT     = 1;
  localparam int          ST_RDPEND   = 2;

  typedef enum logic [1:0] {OP_NONE, OP_INC, OP_READ, OP_INIT} ebc_op_type;

  // Plain default table: bin i ends at 8*i+7
  function automatic logic [N_BOUND*BYTE_W-1:0] def_bounds();
    logic [N_BOUND*BYTE_W-1:0] t;
    t = '0;
    for (int i = 0; i < N_BOUND; i++) begin
      t[i*BYTE_W +: BYTE_W] = BYTE_W'(i * 8 + 7);
    end
    return t;
  endfunction

  localparam logic [N_BOUND*BYTE_W-1:0] DEF_BOUNDS = def_bounds();

endpackage

`default_nettype wire

// ==== hw/ebc_binner.sv ====
// Boundary table and comparison stage with one output register.
// Assumes the table port is written from the register bus, same clock.
`timescale 1ns/1ps
`default_nettype none

module ebc_binner #(
  parameter int                      NB   = ebc_pkg::N_BOUND,
  parameter logic [NB*8-1:0]         INIT = ebc_pkg::DEF_BOUNDS
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  binned_i,
  input  wire logic                  in_valid_i,
  input  wire logic                  in_chip_i,
  input  wire logic [7:0]            in_value_i,
  output logic                       in_ready_o,
  output logic                       out_valid_o,
  output logic                       out_chip_o,
  output logic [7:0]                 out_index_o,
  input  wire logic                  out_ready_i,
  input  wire logic                  tbl_we_i,
  input  wire logic [4:0]            tbl_idx_i,
  input  wire logic [7:0]            tbl_wdata_i,
  output logic [7:0]                 tbl_rdata_o
);
  import ebc_pkg::*;

  if (NB != N_BOUND) begin : g_chk
    $error("ebc_binner: table must hold 31 entries");
  end

  logic [7:0] bound_ff [NB];
  logic [7:0] bin_idx;
  logic       out_valid_ff;
  logic       out_chip_ff;
  logic [7:0] out_index_ff;

  // Power-on table from parameter, one table for both particle types
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NB; i++) begin
        bound_ff[i] <= INIT[i*8 +: 8]; // R6
      end
    end else if (tbl_we_i && tbl_idx_i < 5'(NB)) begin
      bound_ff[tbl_idx_i] <= tbl_wdata_i; // R5
    end
  end

  assign tbl_rdata_o = (tbl_idx_i < 5'(NB)) ? bound_ff[tbl_idx_i] : 8'h00;

  // Start at last bin, first boundary with value <= wins
  always_comb begin
    bin_idx = BIN_LAST; // R7
    for (int i = NB - 1; i >= 0; i--) begin
      if (in_value_i <= bound_ff[i]) begin // R4
        bin_idx = 8'(i); // R7
      end
    end
  end

  assign in_ready_o = !out_valid_ff || out_ready_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_ff <= 1'b0;
      out_chip_ff  <= 1'b0;
      out_index_ff <= 8'h00;
    end else if (in_ready_o) begin
      out_valid_ff <= in_valid_i;
      out_chip_ff  <= in_chip_i;
      out_index_ff <= binned_i ? bin_idx : in_value_i; // R1 R8
    end
  end

  assign out_valid_o = out_valid_ff;
  assign out_chip_o  = out_chip_ff;
  assign out_index_o = out_index_ff;

endmodule

`default_nettype wire

// ==== hw/ebc_top.sv ====
// Event binning and counter store for one telescope.
// Assumes two front-end chips on pins, a byte-wide static RAM and a
// classic Wishbone master on clk_i.
// Summary of operation
// R1: Counting mode selectable: 256 direct or 32 bins
// R2: Two event handshakes in, one increment handshake out
// R3: Arbiter shares table without limiting event bandwidth
// R4: 33 boundaries, 0 and 255 implicit, 31 stored
// R5: Each boundary entry is eight bits
// R6: Power-on table is a design parameter, shared
// R7: Start at 31, first boundary value<=entry wins
// R8: Counter index 8 bits, binned range 0..31
// R9: Four pages, one counting page for both chips
// R10: Readout any page while counting; read clears counter
// R11: 24-bit counters saturate at all ones
// R12: Saturation pulses event and sets sticky interrupt
// R13: External memory byte-wide, at least 8192 locations
// R14: Update is three byte reads then three writes
// R15: No memory init at reset; init command clears
// R16: Strict 9-clock slot cycle, idle strobes deasserted
// R17: Address is chip, page, index, byte bits
// R18: Counters word aligned, msb at 01b, lsb 11b
// R19: Bytes accessed least significant first
// R20: Counter read-out presents most significant byte first
// R21: Simultaneous events served alternately
`timescale 1ns/1ps
`default_nettype none

module ebc_top #(
  parameter logic [ebc_pkg::N_BOUND*8-1:0] BOUND_INIT = ebc_pkg::DEF_BOUNDS
) (
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic [7:0]                        wb_adr_i,
  input  wire logic [31:0]                       wb_dat_i,
  output logic [31:0]                            wb_dat_o,
  input  wire logic                              wb_we_i,
  input  wire logic [3:0]                        wb_sel_i,
  input  wire logic                              wb_cyc_i,
  input  wire logic                              wb_stb_i,
  output logic                                   wb_ack_o,
  input  wire logic [1:0]                        fe_valid_i,
  input  wire logic [7:0]                        fe_data0_i,
  input  wire logic [7:0]                        fe_data1_i,
  output logic [1:0]                             fe_ready_o,
  output logic [ebc_pkg::MEM_ADDR_W-1:0]         mem_addr_o,
  output logic [7:0]                             mem_dat_o,
  input  wire logic [7:0]                        mem_dat_i,
  output logic                                   mem_dat_oe_o,
  output logic                                   mem_ce_n_o,
  output logic                                   mem_oe_n_o,
  output logic                                   mem_we_n_o,
  output logic                                   sat_event_o,
  output logic                                   sat_irq_o
);
  import ebc_pkg::*;

  function automatic logic [MEM_ADDR_W-1:0] mk_addr(input logic chip, input logic [1:0] page,
                                                     input logic [7:0] idx, input logic [1:0] ofs);
    return {chip, page, idx, ofs}; // R17 R18
  endfunction

  // Byte j of a counter, lsb first, sits at offset 3-j
  function automatic logic [1:0] byte_ofs(input logic [3:0] j);
    return OFS_LSB - j[1:0]; // R18 R19
  endfunction

  // Front-end sync and holding
  logic [1:0]  fe_vq1_ff;
  logic [1:0]  fe_vq2_ff;
  logic [7:0]  fe_dq1_ff [2];
  logic [7:0]  fe_dq2_ff [2];
  logic [1:0]  fe_ready_ff;
  logic [1:0]  hold_valid_ff;
  logic [7:0]  hold_data_ff [2];
  logic        prefer1_ff;
  logic        arb_sel;
  logic        arb_take;
  logic        bin_in_ready;
  // Control registers
  logic        binned_ff;
  logic [1:0]  page_ff;
  logic        count_en_ff;
  // Increment request
  logic        bin_valid;
  logic        bin_chip;
  logic [7:0]  bin_index;
  logic        inc_valid_ff;
  logic        inc_chip_ff;
  logic [7:0]  inc_idx_ff;
  // Sequencer
  logic [3:0]  slot_ff;
  ebc_op_type  op_ff;
  logic        op_chip_ff;
  logic [1:0]  op_page_ff;
  logic [7:0]  op_idx_ff;
  logic [23:0] cnt_ff;
  logic [23:0] wval;
  logic [3:0]  wr_j;
  logic [3:0]  cap_j;
  logic [7:0]  mem_q1_ff;
  logic [7:0]  mem_q2_ff;
  logic        slot_end;
  logic        take_init;
  logic        take_rd;
  logic        take_inc;
  logic        init_busy_ff;
  logic [8:0]  init_ptr_ff;
  logic        rd_pend_ff;
  logic        rd_chip_ff;
  logic [1:0]  rd_page_ff;
  logic [7:0]  rd_idx_ff;
  logic [23:0] rd_val_ff;
  logic        rd_valid_ff;
  logic        sat_hit;
  logic        sat_pulse_ff;
  logic        sat_flag_ff;
  // Bus
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic        bus_req;
  logic        bus_wr;
  logic        wr_byte0;
  logic        tbl_sel;
  logic        tbl_we;
  logic [7:0]  tbl_rdata;
  logic [31:0] rdata;

  // Two-flop synchronisers on the front-end pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fe_vq1_ff <= 2'h0;
      fe_vq2_ff <= 2'h0;
      for (int c = 0; c < 2; c++) begin
        fe_dq1_ff[c] <= 8'h00;
        fe_dq2_ff[c] <= 8'h00;
      end
    end else begin
      fe_vq1_ff    <= fe_valid_i;
      fe_vq2_ff    <= fe_vq1_ff;
      fe_dq1_ff[0] <= fe_data0_i;
      fe_dq1_ff[1] <= fe_data1_i;
      fe_dq2_ff[0] <= fe_dq1_ff[0];
      fe_dq2_ff[1] <= fe_dq1_ff[1];
    end
  end

  // Four-phase event handshake per chip with one holding register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fe_ready_ff   <= 2'h0;
      hold_valid_ff <= 2'h0;
      hold_data_ff[0] <= 8'h00;
      hold_data_ff[1] <= 8'h00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (!fe_vq2_ff[c]) begin
          fe_ready_ff[c] <= 1'b0; // R2
        end else if (!fe_ready_ff[c] && !hold_valid_ff[c]) begin
          fe_ready_ff[c]  <= 1'b1; // R2
          hold_data_ff[c] <= fe_dq2_ff[c];
        end
        if (fe_vq2_ff[c] && !fe_ready_ff[c] && !hold_valid_ff[c]) begin
          hold_valid_ff[c] <= 1'b1;
        end else if (arb_take && arb_sel == 1'(c)) begin
          hold_valid_ff[c] <= 1'b0;
        end
      end
    end
  end

  assign fe_ready_o = fe_ready_ff;

  // One event per clock into the binner; tie goes to the other chip
  assign arb_sel  = hold_valid_ff[1] && (!hold_valid_ff[0] || prefer1_ff); // R21
  assign arb_take = (|hold_valid_ff) && bin_in_ready; // R3

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prefer1_ff <= 1'b0;
    end else if (arb_take && (&hold_valid_ff)) begin
      prefer1_ff <= !arb_sel; // R21
    end
  end

  ebc_binner #(
    .NB          (N_BOUND),
    .INIT        (BOUND_INIT)
  ) u_binner (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .binned_i    (binned_ff),
    .in_valid_i  (arb_take && count_en_ff),
    .in_chip_i   (arb_sel),
    .in_value_i  (hold_data_ff[arb_sel]),
    .in_ready_o  (bin_in_ready),
    .out_valid_o (bin_valid),
    .out_chip_o  (bin_chip),
    .out_index_o (bin_index),
    .out_ready_i (!inc_valid_ff),
    .tbl_we_i    (tbl_we),
    .tbl_idx_i   (wb_adr_i[6:2]),
    .tbl_wdata_i (wb_dat_i[7:0]),
    .tbl_rdata_o (tbl_rdata)
  );

  // Increment request register toward the counter unit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inc_valid_ff <= 1'b0;
      inc_chip_ff  <= 1'b0;
      inc_idx_ff   <= 8'h00;
    end else if (!inc_valid_ff) begin
      inc_valid_ff <= bin_valid; // R2
      inc_chip_ff  <= bin_chip;
      inc_idx_ff   <= bin_index;
    end else if (take_inc) begin
      inc_valid_ff <= 1'b0;
    end
  end

  // Choice of the next slot cycle's operation
  assign slot_end  = (slot_ff == SLOT_LAST);
  assign take_init = slot_end && init_busy_ff;
  assign take_rd   = slot_end && !init_busy_ff && rd_pend_ff;
  assign take_inc  = slot_end && !init_busy_ff && !rd_pend_ff && inc_valid_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_ff    <= 4'h0;
      op_ff      <= OP_NONE;
      op_chip_ff <= 1'b0;
      op_page_ff <= 2'h0;
      op_idx_ff  <= 8'h00;
    end else begin
      slot_ff <= slot_end ? 4'h0 : slot_ff + 4'h1; // R16
      if (take_init) begin
        op_ff      <= OP_INIT; // R15
        op_chip_ff <= init_ptr_ff[8];
        op_page_ff <= page_ff;
        op_idx_ff  <= init_ptr_ff[7:0];
      end else if (take_rd) begin
        op_ff      <= OP_READ; // R10
        op_chip_ff <= rd_chip_ff;
        op_page_ff <= rd_page_ff;
        op_idx_ff  <= rd_idx_ff;
      end else if (take_inc) begin
        op_ff      <= OP_INC;
        op_chip_ff <= inc_chip_ff;
        op_page_ff <= page_ff; // R9
        op_idx_ff  <= inc_idx_ff;
      end else if (slot_end) begin
        op_ff <= OP_NONE; // R16
      end
    end
  end

  // Memory read data pins, two flops before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_q1_ff <= 8'h00;
      mem_q2_ff <= 8'h00;
    end else begin
      mem_q1_ff <= mem_dat_i;
      mem_q2_ff <= mem_q1_ff;
    end
  end

  // Counter assembly, byte read in slot k lands at slot k+3
  assign cap_j = slot_ff - SLOT_CAP0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 24'h000000;
    end else if (slot_ff >= SLOT_CAP0 && slot_ff <= SLOT_CAP_END) begin
      cnt_ff[cap_j[1:0]*8 +: 8] <= mem_q2_ff; // R19
    end
  end

  // Saturating increment; read-out and init write zero
  always_comb begin
    wval = 24'h000000; // R10 R15
    if (op_ff == OP_INC) begin
      wval = (cnt_ff == CNT_ALL1) ? cnt_ff : cnt_ff + 24'h000001; // R11
    end
  end

  assign wr_j    = slot_ff - SLOT_WR0;
  assign sat_hit = (op_ff == OP_INC) && (slot_ff == SLOT_WR0) && (cnt_ff == CNT_ALL1);

  // Memory strobes: three reads then three writes, only the three writes for init, idle high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_addr_o   <= '0;
      mem_dat_o    <= 8'h00;
      mem_dat_oe_o <= 1'b0;
      mem_ce_n_o   <= 1'b1;
      mem_oe_n_o   <= 1'b1;
      mem_we_n_o   <= 1'b1;
    end else begin
      mem_dat_oe_o <= 1'b0;
      mem_ce_n_o   <= 1'b1; // R16
      mem_oe_n_o   <= 1'b1;
      mem_we_n_o   <= 1'b1;
      if (op_ff != OP_NONE && op_ff != OP_INIT && slot_ff <= SLOT_RD_END) begin
        mem_ce_n_o <= 1'b0; // R14
        mem_oe_n_o <= 1'b0;
        mem_addr_o <= mk_addr(op_chip_ff, op_page_ff, op_idx_ff, byte_ofs(slot_ff)); // R19
      end else if (op_ff != OP_NONE && slot_ff >= SLOT_WR0) begin
        mem_ce_n_o   <= 1'b0; // R14
        mem_we_n_o   <= 1'b0;
        mem_dat_oe_o <= 1'b1;
        mem_dat_o    <= wval[wr_j[1:0]*8 +: 8];
        mem_addr_o   <= mk_addr(op_chip_ff, op_page_ff, op_idx_ff, byte_ofs(wr_j)); // R19
      end
    end
  end

  // Init sweep over both chips' counters of the counting page
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_busy_ff <= 1'b0;
      init_ptr_ff  <= 9'h000;
    end else if (bus_wr && wr_byte0 && wb_adr_i == ADR_CMD && wb_dat_i[CMD_INIT]) begin
      init_busy_ff <= 1'b1; // R15
      init_ptr_ff  <= 9'h000;
    end else if (take_init) begin
      init_ptr_ff <= init_ptr_ff + 9'h001;
      if (init_ptr_ff == INIT_LAST) begin
        init_busy_ff <= 1'b0;
      end
    end
  end

  // Read-out request and captured value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_pend_ff  <= 1'b0;
      rd_chip_ff  <= 1'b0;
      rd_page_ff  <= 2'h0;
      rd_idx_ff   <= 8'h00;
      rd_val_ff   <= 24'h000000;
      rd_valid_ff <= 1'b0;
    end else begin
      if (bus_wr && wb_sel_i[1:0] == 2'h3 && wb_adr_i == ADR_RDREQ) begin
        rd_pend_ff  <= 1'b1; // R10
        rd_idx_ff   <= wb_dat_i[7:0];
        rd_page_ff  <= wb_dat_i[RQ_PAGE +: 2];
        rd_chip_ff  <= wb_dat_i[RQ_CHIP];
        rd_valid_ff <= 1'b0;
      end else if (take_rd) begin
        rd_pend_ff <= 1'b0;
      end else if (op_ff == OP_READ && slot_ff == SLOT_WR0) begin
        rd_val_ff   <= cnt_ff; // R10
        rd_valid_ff <= 1'b1;
      end
    end
  end

  // Saturation event pulse and sticky flag, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sat_pulse_ff <= 1'b0;
      sat_flag_ff  <= 1'b0;
    end else begin
      sat_pulse_ff <= sat_hit; // R12
      if (sat_hit) begin
        sat_flag_ff <= 1'b1; // R12
      end else if (bus_wr && wr_byte0 && wb_adr_i == ADR_CMD && wb_dat_i[CMD_IRQCLR]) begin
        sat_flag_ff <= 1'b0;
      end
    end
  end

  assign sat_event_o = sat_pulse_ff;
  assign sat_irq_o   = sat_flag_ff;

  // Wishbone slave, one wait state, ack for one cycle
  assign bus_req  = wb_cyc_i && wb_stb_i && !ack_ff;
  assign bus_wr   = bus_req && wb_we_i;
  assign wr_byte0 = wb_sel_i[0];
  assign tbl_sel  = wb_adr_i[7] && (wb_adr_i[6:2] < 5'(N_BOUND));
  assign tbl_we   = bus_wr && wr_byte0 && tbl_sel;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      binned_ff   <= 1'b0;
      page_ff     <= 2'h0;
      count_en_ff <= 1'b0;
    end else if (bus_wr && wr_byte0 && wb_adr_i == ADR_CTRL) begin
      binned_ff   <= wb_dat_i[CTRL_BINNED]; // R1
      page_ff     <= wb_dat_i[CTRL_PAGE +: 2]; // R9
      count_en_ff <= wb_dat_i[CTRL_EN];
    end
  end

  // Read mux; the counter's msb byte sits highest so it leaves first
  always_comb begin
    rdata = 32'h00000000;
    if (wb_adr_i == ADR_CTRL) begin
      rdata[CTRL_BINNED]     = binned_ff;
      rdata[CTRL_PAGE +: 2]  = page_ff;
      rdata[CTRL_EN]         = count_en_ff;
    end else if (wb_adr_i == ADR_RDREQ) begin
      rdata[7:0]             = rd_idx_ff;
      rdata[RQ_PAGE +: 2]    = rd_page_ff;
      rdata[RQ_CHIP]         = rd_chip_ff;
    end else if (wb_adr_i == ADR_RDDATA) begin
      rdata[23:0]            = rd_val_ff; // R20
      rdata[RD_VALID]        = rd_valid_ff;
    end else if (wb_adr_i == ADR_STATUS) begin
      rdata[ST_SAT]          = sat_flag_ff;
      rdata[ST_INIT]         = init_busy_ff || op_ff == OP_INIT;
      rdata[ST_RDPEND]       = rd_pend_ff || (op_ff == OP_READ && !rd_valid_ff);
    end else if (tbl_sel) begin
      rdata[7:0]             = tbl_rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else begin
      ack_ff <= bus_req;
      if (bus_req && !wb_we_i) begin
        dat_ff <= rdata;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

endmodule

`default_nettype wire

// ==== verif/ebc_ram_model.sv ====
// Byte-wide static RAM on the counter memory pins.
// Assumes the bench resolves the shared data bus into bus_i.
`timescale 1ns/1ps
`default_nettype none
module ebc_ram_model (
  input  wire logic        clk_i,
  input  wire logic [12:0] addr_i,
  input  wire logic [7:0]  bus_i,
  output logic [7:0]       dat_o,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i
);
  logic [7:0] mem [0:8191];
  logic [7:0] last = 8'h00;
  // Power-up garbage
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end
  always @(posedge clk_i) begin
    if (!ce_n_i && !we_n_i) begin
      mem[addr_i] <= bus_i;
    end
    if (!ce_n_i && !oe_n_i) begin
      last <= mem[addr_i];
    end
  end
  // Released bus shows the inverse of the last byte
  assign dat_o = (!ce_n_i && !oe_n_i) ? mem[addr_i] : ~last;
endmodule
`default_nettype wire

// ==== verif/ebc_top_sva.sv ====
// Checker of the memory slot cycle and saturation outputs.
// Assumes binding to ebc_top, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ebc_top_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [12:0] mem_addr_o,
  input wire logic [7:0]  mem_dat_o,
  input wire logic        mem_dat_oe_o,
  input wire logic        mem_ce_n_o,
  input wire logic        mem_oe_n_o,
  input wire logic        mem_we_n_o,
  input wire logic        sat_event_o,
  input wire logic        sat_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] ph_ff;
  logic       seen_ff;
  // Slot phase locked to the first read seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen_ff <= 1'b0;
      ph_ff <= 4'h0;
    end else if (!seen_ff && !mem_oe_n_o && mem_addr_o[1:0] == 2'h3) begin
      seen_ff <= 1'b1;
      ph_ff <= 4'h1;
    end else begin
      ph_ff <= (ph_ff == 4'h8) ? 4'h0 : ph_ff + 4'h1;
    end
  end
  property p_idle; mem_ce_n_o |-> mem_oe_n_o && mem_we_n_o; endproperty
  a_idle: assert property (p_idle) else $error("strobe while idle");
  property p_slot;
    !mem_ce_n_o && seen_ff |-> ph_ff == (mem_oe_n_o ? 4'h6 : 4'h0) + 4'h3 - {2'h0, mem_addr_o[1:0]};
  endproperty
  a_slot: assert property (p_slot) else $error("access off slot");
  property p_rdseq;
    !mem_oe_n_o && mem_addr_o[1:0] == 2'h3 |=> !mem_oe_n_o && mem_addr_o[1:0] == 2'h2
      ##1 !mem_oe_n_o && mem_addr_o[1:0] == 2'h1 ##1 mem_ce_n_o [*3];
  endproperty
  a_rdseq: assert property (p_rdseq) else $error("read order");
  property p_wrrd;
    !mem_oe_n_o && mem_addr_o[1:0] == 2'h1 |-> ##4 !mem_we_n_o && mem_addr_o[1:0] == 2'h3
      && mem_addr_o[12:2] == $past(mem_addr_o[12:2], 4);
  endproperty
  a_wrrd: assert property (p_wrrd) else $error("no write back");
  property p_ofs; !mem_ce_n_o |-> mem_addr_o[1:0] != 2'h0; endproperty
  a_ofs: assert property (p_ofs) else $error("offset 0 used");
  property p_bus; !mem_oe_n_o |-> !mem_dat_oe_o; endproperty
  a_bus: assert property (p_bus) else $error("bus clash");
  property p_irq; sat_event_o |-> ##[0:1] sat_irq_o; endproperty
  a_irq: assert property (p_irq) else $error("flag not set");
  property p_sat; sat_event_o |-> mem_dat_o == 8'hff && !mem_we_n_o && mem_addr_o[1:0] == 2'h3; endproperty
  a_sat: assert property (p_sat) else $error("saturated value lost");
  c_sat: cover property (sat_event_o);
  c_rd: cover property (!mem_oe_n_o);
  c_wr: cover property (!mem_we_n_o);
endmodule
bind ebc_top ebc_top_sva ebc_top_sva_inst (.*);
`default_nettype wire

// ==== verif/ebc_top_bench.sv ====
// Bench for ebc_top: init, direct and binned counting, read-out, saturation.
// Assumes the RAM model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ebc_top_bench;
  import ebc_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  wa = 8'h00;
  logic [31:0] wd = '0;
  logic [31:0] rd;
  logic        we = 1'b0;
  logic        cyc = 1'b0;
  logic        ack;
  logic [1:0]  fv = 2'b00;
  logic [7:0]  d0 = 8'h00;
  logic [7:0]  d1 = 8'h00;
  logic [1:0]  frdy;
  logic [12:0] ma;
  logic [7:0]  mw, mr, mbus;
  logic        moe, ce_n, oe_n, we_n, sev, sirq;
  logic [31:0] seed = 32'hdfafc022;
  logic [7:0]  bnd [31];
  int          fail_count = 0;
  int          cmp_count = 0;
  int          expv [2][256];
  always #4 clk_i = ~clk_i;
  assign mbus = moe ? mw : mr;
  ebc_top ebc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wa), .wb_dat_i(wd), .wb_dat_o(rd),
    .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack), .fe_valid_i(fv),
    .fe_data0_i(d0), .fe_data1_i(d1), .fe_ready_o(frdy), .mem_addr_o(ma), .mem_dat_o(mw),
    .mem_dat_i(mbus), .mem_dat_oe_o(moe), .mem_ce_n_o(ce_n), .mem_oe_n_o(oe_n), .mem_we_n_o(we_n),
    .sat_event_o(sev), .sat_irq_o(sirq));
  ebc_ram_model ebc_ram_model_inst (.clk_i(clk_i), .addr_i(ma), .bus_i(mbus), .dat_o(mr),
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] bin_of(input logic [7:0] v);
    for (int i = 0; i < N_BOUND; i++) begin
      if (v <= bnd[i]) begin
        return 8'(i);
      end
    end
    return BIN_LAST;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    wa <= a;
    wd <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rd;
    cyc <= 1'b0;
    fail_count += (n >= 50);
  endtask
  task automatic ev(input int c, input logic b, input logic [7:0] v);
    int n;
    expv[c][b ? bin_of(v) : v]++;
    repeat (xs() % 3) @(posedge clk_i);
    @(posedge clk_i);
    if (c == 1) d1 <= v; else d0 <= v;
    fv[c] <= 1'b1;
    n = 0;
    while (frdy[c] !== 1'b1 && n < 200) begin @(posedge clk_i); n++; end
    fv[c] <= 1'b0;
    while (frdy[c] !== 1'b0 && n < 400) begin @(posedge clk_i); n++; end
    fail_count += (n >= 200);
  endtask
  task automatic rd_cnt(input logic c, input logic [1:0] p, input logic [7:0] k);
    logic [31:0] q;
    int n;
    chk(32'(ebc_ram_model_inst.mem[{c, p, k, OFS_LSB}]), 32'(expv[c][k][7:0]));
    chk(32'(ebc_ram_model_inst.mem[{c, p, k, 2'h1}]), 32'(expv[c][k][23:16]));
    wb(1'b1, ADR_RDREQ, {21'h0, c, p, k}, q);
    n = 0;
    do begin wb(1'b0, ADR_RDDATA, 32'h0, q); n++; end while (q[RD_VALID] !== 1'b1 && n < 40);
    chk({7'h0, q[RD_VALID:0]}, {7'h0, 1'b1, 24'(expv[c][k])});
    chk(32'(ebc_ram_model_inst.mem[{c, p, k, OFS_LSB}]), 32'h0);
    expv[c][k] = 0;
  endtask
  task automatic run(input logic b, input logic [1:0] p);
    logic [31:0] q;
    localparam logic [7:0] CORN [5] = '{8'h00, 8'h07, 8'hf7, 8'hf8, 8'hff};
    int n;
    wb(1'b1, ADR_CTRL, 32'(b) | (32'(p) << CTRL_PAGE) | 32'h8, q);
    wb(1'b1, ADR_CMD, 32'h2, q);
    n = 0;
    do begin wb(1'b0, ADR_STATUS, 32'h0, q); n++; end while (q[ST_INIT] !== 1'b0 && n < 3000);
    chk({31'h0, q[ST_INIT]}, 32'h0);
    fork
      for (int j = 0; j < 17; j++) ev(0, b, j < 5 ? CORN[j] : 8'(xs()));
      for (int j = 0; j < 17; j++) ev(1, b, j < 5 ? CORN[j] : 8'(xs()));
    join
    // In-flight increments drain within a few slot cycles
    repeat (120) @(posedge clk_i);
    for (int k = 0; k < (b ? 32 : 256); k++) begin
      rd_cnt(1'b0, p, 8'(k));
      rd_cnt(1'b1, p, 8'(k));
    end
    $display("run binned=%0d done", b);
  endtask
  initial begin
    logic [31:0] q;
    int n;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (20) begin @(posedge clk_i); chk({31'h0, ce_n}, 32'h1); end
    wb(1'b0, 8'hfc, 32'h0, q);
    chk(q, 32'h0);
    for (int i = 0; i < N_BOUND; i++) begin
      bnd[i] = 8'(i * 8 + 7);
      wb(1'b0, ADR_BOUND + 8'(4 * i), 32'h0, q);
      chk(q, 32'(bnd[i]));
    end
    run(1'b0, 2'h1);
    bnd[0] = 8'h20;
    wb(1'b1, ADR_BOUND, 32'h20, q);
    run(1'b1, 2'h2);
    for (int j = 1; j < 4; j++) ebc_ram_model_inst.mem[{3'h2, 8'h05, 2'(j)}] = 8'hff;
    ev(0, 1'b1, 8'h2c);
    expv[0][5] = 32'hffffff;
    n = 0;
    while (sirq !== 1'b1 && n < 100) begin @(posedge clk_i); n++; end
    chk({31'h0, sev}, 32'h1);
    chk({31'h0, sirq}, 32'h1);
    rd_cnt(1'b0, 2'h2, 8'h05);
    wb(1'b1, ADR_CMD, 32'h1, q);
    wb(1'b0, ADR_STATUS, 32'h0, q);
    chk({31'h0, q[ST_SAT] | sirq}, 32'h0);
    $display("saturation done");
    final_report();
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
